// ---- src/exclp_defs.vh ----
// Constants for the exception and low-power control block.
// Assumes an APB master with 16-bit byte addresses and 32-bit data.
`ifndef EXCLP_DEFS_VH
`define EXCLP_DEFS_VH

// =====================================================
// Register map (byte addresses)
`define EXCLP_ADDR_FLAGS_ONE   16'hFE04
`define EXCLP_ADDR_FLAGS_TWO   16'hFE08
`define EXCLP_ADDR_FLAGS_THREE 16'hFE0C
`define EXCLP_ADDR_BRK_STATUS  16'hFE10
`define EXCLP_ADDR_BRK_FLAGCTL 16'hFE14
`define EXCLP_ADDR_CONFIG_ONE  16'hFE18

// =====================================================
// Field positions and reset values
`define EXCLP_STOPWAIT_BIT 1
`define EXCLP_CLR_EN_BIT   7
`define EXCLP_SHORT_BIT    0
`define EXCLP_RST_BYTE     8'h00
`define EXCLP_RST_WORD     32'h0000_0000

// =====================================================
// Request lines and vectors
`define EXCLP_NREQ      17
`define EXCLP_VEC_TRAP  5'h00
`define EXCLP_VEC_W     5

// =====================================================
// Stop recovery, in oscillator cycles
`define EXCLP_CNT_W      12
`define EXCLP_RECOV_LONG 12'hFFF
`define EXCLP_RECOV_SHRT 12'h01F

`endif

// ---- src/exclp_recov.v ----
// Stop recovery timer for the exception and low-power block.
// Assumes osc_clk is synchronous to sys_clk and slower than it.
`timescale 1ns/1ps
`include "exclp_defs.vh"

module exclp_recov (
    // Clock and reset
    input  wire                     sys_clk,
    input  wire                     rst_n,
    // Control
    input  wire                     osc_clk,
    input  wire                     hold,
    input  wire                     short_sel,
    // Result
    output reg                      done,
    output reg  [`EXCLP_CNT_W-1:0] count
);

    reg                    osc_q;
    wire                   osc_fall;
    wire [`EXCLP_CNT_W-1:0] last;

    assign osc_fall = osc_q & ~osc_clk;
    assign last     = short_sel ? `EXCLP_RECOV_SHRT : `EXCLP_RECOV_LONG;

    // =====================================================
    // Counter: held clear, then advanced on oscillator falls
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            osc_q <= 1'b0;
            count <= {`EXCLP_CNT_W{1'b0}};
            done  <= 1'b0;
        end else begin
            osc_q <= osc_clk;
            if (hold) begin
                count <= {`EXCLP_CNT_W{1'b0}};
                done  <= 1'b0;
            end else if (osc_fall && !done) begin
                count <= count + 1'b1;
                done  <= (count == last);
            end
        end
    end

endmodule

// ---- src/exclp_top.v ----
// Exception sequencing and low-power control with APB status registers.
// Assumes a CPU core that stacks and fetches on the strobes given here.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "exclp_defs.vh"

module exclp_top (
    // Clock and reset
    input  wire                      sys_clk,
    input  wire                      rst_n,
    input  wire                      osc_clk,
    // APB slave
    input  wire                      psel,
    input  wire                      penable,
    input  wire                      pwrite,
    input  wire [15:0]               paddr,
    input  wire [31:0]               pwdata,
    output reg  [31:0]               prdata,
    output reg                       pready,
    output reg                       pslverr,
    // Request sources
    input  wire [`EXCLP_NREQ-1:0]    irq_req,
    input  wire [`EXCLP_NREQ-1:0]    irq_en,
    input  wire                      break_req,
    // CPU core
    input  wire                      i_mask,
    input  wire                      instr_done,
    input  wire                      trap_exec,
    input  wire                      wait_exec,
    input  wire                      stop_exec,
    input  wire                      handler_ret,
    input  wire                      vec_ack,
    output reg                       int_take,
    output reg  [`EXCLP_VEC_W-1:0]   vec_sel,
    output reg                       stack_pc_dec,
    output reg                       stack_index_high,
    output reg                       set_imask,
    output reg                       clr_imask,
    output reg                       drop_prefetch,
    output reg                       cpu_clk_en,
    output reg                       base_clock_output,
    // Break support
    output reg                       break_mode,
    output reg                       break_clear_allow
);

    // =====================================================
    // States
    localparam [2:0] ST_RUN   = 3'h0;
    localparam [2:0] ST_WAIT  = 3'h1;
    localparam [2:0] ST_STOP  = 3'h2;
    localparam [2:0] ST_RECOV = 3'h3;
    localparam [2:0] ST_ENTRY = 3'h4;

    reg  [2:0]                state;
    reg                       lat_valid;
    reg  [`EXCLP_VEC_W-1:0]   lat_vec;
    reg                       wake_brk;
    reg                       wake_rec;
    reg                       break_stopwait_status;
    reg                       break_clear_enable;
    reg                       short_recovery_select;
    wire                      recov_done;
    wire [`EXCLP_NREQ-1:0]    live;
    wire                      any_live;
    wire [`EXCLP_VEC_W-1:0]   best_vec;

    // =====================================================
    // Priority: lowest flag number wins
    function [`EXCLP_VEC_W-1:0] pick;
        input [`EXCLP_NREQ-1:0] r;
        integer                 k;
        begin
            pick = `EXCLP_VEC_TRAP;
            for (k = `EXCLP_NREQ - 1; k >= 0; k = k - 1) begin
                if (r[k]) begin
                    pick = k[`EXCLP_VEC_W-1:0] + 1'b1;
                end
            end
        end
    endfunction

    // Enabled requests only
    assign live     = irq_req & irq_en;
    assign any_live = |live;
    assign best_vec = pick(live);

    // =====================================================
    // Stop recovery timer
    exclp_recov u_recov (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .osc_clk   (osc_clk),
        .hold      (state != ST_RECOV),
        .short_sel (short_recovery_select),
        .done      (recov_done),
        .count     ()
    );

    // =====================================================
    // Exception sequencer
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            // Reset beats every exception, no arbitration
            state             <= ST_RUN;
            lat_valid         <= 1'b0;
            lat_vec           <= `EXCLP_VEC_TRAP;
            wake_brk          <= 1'b0;
            wake_rec          <= 1'b0;
            int_take          <= 1'b0;
            vec_sel           <= `EXCLP_VEC_TRAP;
            stack_pc_dec      <= 1'b0;
            stack_index_high  <= 1'b0;
            set_imask         <= 1'b0;
            clr_imask         <= 1'b0;
            drop_prefetch     <= 1'b0;
            cpu_clk_en        <= 1'b1;
            base_clock_output <= 1'b1;
            break_mode        <= 1'b0;
        end else begin
            int_take         <= 1'b0;
            set_imask        <= 1'b0;
            clr_imask        <= 1'b0;
            drop_prefetch    <= 1'b0;
            stack_index_high <= 1'b0;
            if (handler_ret) begin
                break_mode <= 1'b0;
            end
            case (state)
                ST_RUN: begin
                    if (instr_done || handler_ret) begin
                        // Examined only at instruction boundaries
                        if (break_req) begin
                            lat_valid    <= 1'b1;
                            lat_vec      <= `EXCLP_VEC_TRAP;
                            stack_pc_dec <= 1'b0;
                            break_mode   <= 1'b1;
                            state        <= ST_ENTRY;
                        end else if (trap_exec && instr_done) begin
                            lat_valid    <= 1'b1;
                            lat_vec      <= `EXCLP_VEC_TRAP;
                            stack_pc_dec <= 1'b0;
                            state        <= ST_ENTRY;
                        end else if (!i_mask && any_live) begin
                            lat_valid     <= 1'b1;
                            lat_vec       <= best_vec;
                            stack_pc_dec  <= 1'b1;
                            drop_prefetch <= handler_ret;
                            state         <= ST_ENTRY;
                        end else if (wait_exec && instr_done) begin
                            clr_imask  <= 1'b1;
                            cpu_clk_en <= 1'b0;
                            state      <= ST_WAIT;
                        end else if (stop_exec && instr_done) begin
                            clr_imask         <= 1'b1;
                            cpu_clk_en        <= 1'b0;
                            base_clock_output <= 1'b0;
                            state             <= ST_STOP;
                        end
                    end
                end
                ST_WAIT: begin
                    // Peripherals keep running; wake on request or break
                    if (break_req) begin
                        wake_brk     <= 1'b1;
                        lat_valid    <= 1'b1;
                        lat_vec      <= `EXCLP_VEC_TRAP;
                        stack_pc_dec <= 1'b0;
                        break_mode   <= 1'b1;
                        cpu_clk_en   <= 1'b1;
                        state        <= ST_ENTRY;
                    end else if (any_live) begin
                        lat_valid    <= 1'b1;
                        lat_vec      <= best_vec;
                        stack_pc_dec <= 1'b1;
                        cpu_clk_en   <= 1'b1;
                        state        <= ST_ENTRY;
                    end
                end
                ST_STOP: begin
                    // Counter held clear until recovery starts
                    if (break_req || any_live) begin
                        wake_rec <= break_req;
                        state    <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (recov_done) begin
                        cpu_clk_en        <= 1'b1;
                        base_clock_output <= 1'b1;
                        lat_valid         <= 1'b1;
                        stack_pc_dec      <= ~wake_rec;
                        lat_vec           <= wake_rec ? `EXCLP_VEC_TRAP : best_vec;
                        break_mode        <= wake_rec | break_mode;
                        wake_brk          <= wake_rec;
                        state             <= ST_ENTRY;
                    end
                end
                ST_ENTRY: begin
                    wake_brk <= 1'b0;
                    // One take per latched choice, held until the CPU takes the vector
                    if (lat_valid) begin
                        int_take  <= 1'b1;
                        set_imask <= 1'b1;
                        vec_sel   <= lat_vec;
                        lat_valid <= 1'b0;
                    end
                    if (vec_ack) begin
                        state     <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // =====================================================
    // Break flag protection for other modules
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            break_clear_allow <= 1'b1;
        end else begin
            // Outside break clears act normally, completing any two-step
            break_clear_allow <= ~break_mode | break_clear_enable;
        end
    end

    // =====================================================
    // APB slave: one wait state, then answer
    wire        acc;
    wire        hit;
    reg  [31:0] next_rdata;
    reg         next_err;

    assign acc = psel & penable & ~pready;

    // Read mux over raw request lines (irq_req), not the enabled ones
    always @* begin
        next_rdata = `EXCLP_RST_WORD;
        next_err   = 1'b0;
        case (paddr)
            `EXCLP_ADDR_FLAGS_ONE: begin
                next_rdata[7:2] = irq_req[5:0];
            end
            `EXCLP_ADDR_FLAGS_TWO: begin
                next_rdata[2:0] = irq_req[8:6];
            end
            `EXCLP_ADDR_FLAGS_THREE: begin
                next_rdata[1:0] = irq_req[16:15];
            end
            `EXCLP_ADDR_BRK_STATUS: begin
                next_rdata[`EXCLP_STOPWAIT_BIT] = break_stopwait_status;
            end
            `EXCLP_ADDR_BRK_FLAGCTL: begin
                next_rdata[`EXCLP_CLR_EN_BIT] = break_clear_enable;
            end
            `EXCLP_ADDR_CONFIG_ONE: begin
                next_rdata[`EXCLP_SHORT_BIT] = short_recovery_select;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    assign hit = psel & penable & pready & pwrite & ~pslverr;

    // Bus answer and writable bits
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            prdata                <= `EXCLP_RST_WORD;
            break_stopwait_status <= 1'b0;
            break_clear_enable    <= 1'b0;
            short_recovery_select <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc & next_err;
            prdata  <= (acc && !pwrite) ? next_rdata : `EXCLP_RST_WORD;
            // Set by break wake wins over a same-cycle clear
            if (wake_brk) begin
                break_stopwait_status <= 1'b1;
            end else if (hit && paddr == `EXCLP_ADDR_BRK_STATUS
                         && !pwdata[`EXCLP_STOPWAIT_BIT]) begin
                break_stopwait_status <= 1'b0;
            end
            if (hit && paddr == `EXCLP_ADDR_BRK_FLAGCTL) begin
                break_clear_enable <= pwdata[`EXCLP_CLR_EN_BIT];
            end
            if (hit && paddr == `EXCLP_ADDR_CONFIG_ONE) begin
                short_recovery_select <= pwdata[`EXCLP_SHORT_BIT];
            end
        end
    end

endmodule

// ---- test/exclp_cpu_model.sv ----
// CPU core stand-in: fetches the vector some cycles after each take.
// Assumes int_take is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps

module exclp_cpu_model (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Handshake
    input  wire logic int_take,
    input  wire logic slow,
    output logic      vec_ack
);
    logic [3:0] wait_cnt;

    // =======================================
    // Vector fetch, prompt (2) or slow (8)
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            vec_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            vec_ack <= 1'b0;
            if (int_take) begin
                wait_cnt <= slow ? 4'h8 : 4'h2;
            end else if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
                vec_ack  <= (wait_cnt == 4'h1);
            end
        end
    end
endmodule

// ---- test/exclp_monitor.sv ----
// Checker for the exception and low-power control block.
// Assumes it is bound to exclp_top and sees only its ports.
`timescale 1ns/1ps
`include "exclp_defs.vh"

module exclp_monitor (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    rst_n,
    // APB
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [15:0]             paddr,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    // Requests and boundaries
    input wire logic [`EXCLP_NREQ-1:0]  irq_req,
    input wire logic                    instr_done,
    input wire logic                    handler_ret,
    // Core strobes
    input wire logic                    int_take,
    input wire logic [`EXCLP_VEC_W-1:0] vec_sel,
    input wire logic                    stack_pc_dec,
    input wire logic                    stack_index_high,
    input wire logic                    set_imask,
    input wire logic                    clr_imask,
    input wire logic                    cpu_clk_en,
    input wire logic                    base_clock_output,
    input wire logic                    break_mode,
    input wire logic                    break_clear_allow
);
    default clocking cb @(posedge sys_clk); endclocking
    logic rst_q;

    // Reset seen at the last edge too, so no one-cycle past value reaches across it
    always @(posedge sys_clk) begin
        rst_q <= rst_n;
    end
    default disable iff (!rst_n || !rst_q);

    // =======================================
    // Steps of a status read and of low-power entry
    sequence s_read_one;
        psel && penable && !pwrite && !pready && paddr == `EXCLP_ADDR_FLAGS_ONE;
    endsequence
    sequence s_lp_entry;
        clr_imask && !cpu_clk_en;
    endsequence

    // =======================================
    // Properties
    property p_take_mask;
        int_take |-> set_imask;
    endproperty
    property p_no_index;
        !stack_index_high;
    endproperty
    property p_hold_vec;
        !int_take |-> $stable(vec_sel);
    endproperty
    property p_take_cause;
        int_take |-> $past(instr_done || handler_ret, 2) || $past(!cpu_clk_en, 2);
    endproperty
    property p_pc_kind;
        int_take |-> stack_pc_dec == (vec_sel != 5'h00);
    endproperty
    property p_lp_entry;
        $fell(cpu_clk_en) |-> s_lp_entry;
    endproperty
    property p_stop_clk;
        $fell(base_clock_output) |-> s_lp_entry;
    endproperty
    property p_allow;
        !$past(break_mode) |-> break_clear_allow;
    endproperty
    property p_flags_one;
        s_read_one ##1 pready |-> prdata == {24'h000000, $past(irq_req[5:0]), 2'h0};
    endproperty

    a_take_mask: assert property (p_take_mask) else $error("take without mask set");
    a_no_index: assert property (p_no_index) else $error("high index stacked");
    a_hold_vec: assert property (p_hold_vec) else $error("latched vector moved");
    a_take_cause: assert property (p_take_cause) else $error("take mid instruction");
    a_pc_kind: assert property (p_pc_kind) else $error("wrong stacked pc kind");
    a_lp_entry: assert property (p_lp_entry) else $error("cpu stopped, mask kept");
    a_stop_clk: assert property (p_stop_clk) else $error("base clock off badly");
    a_allow: assert property (p_allow) else $error("clear blocked outside break");
    a_flags_one: assert property (p_flags_one) else $error("status one wrong");
endmodule

bind exclp_top exclp_monitor u_mon (.*);

// ---- test/exclp_top_tb.sv ----
// Self-checking bench for the exception and low-power control block.
// Assumes the CPU stand-in answers each take with a vector fetch.
`timescale 1ns/1ps
`include "exclp_defs.vh"
`define CHK(nm, ex, got) begin n_checks = n_checks + 1; \
    if ((got) !== (ex)) begin n_errors = n_errors + 1; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module exclp_top_tb;
    typedef struct packed {
        logic        wr;
        logic [16:0] req;
        logic [15:0] addr;
        logic [31:0] exp;
        logic        err;
    } exclp_row_t;
    logic        sys_clk = 1'b0, rst_n, osc_clk, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [16:0] irq_req, irq_en;
    logic        break_req, i_mask, instr_done, trap_exec, wait_exec, stop_exec, handler_ret;
    logic        vec_ack, int_take, stack_pc_dec, stack_index_high, set_imask, clr_imask;
    logic        drop_prefetch, cpu_clk_en, base_clock_output, break_mode, break_clear_allow;
    logic        slow, er, t_dec, t_imask, drop_seen, clr_seen;
    logic [4:0]  vec_sel, t_vec;
    logic [1:0]  osc_div;
    integer      n_errors = 0, n_checks = 0, n_falls = 0, took, i, k, f0;
    exclp_row_t  rows [0:10];

    exclp_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .osc_clk(osc_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_en(irq_en),
        .break_req(break_req), .i_mask(i_mask), .instr_done(instr_done), .trap_exec(trap_exec),
        .wait_exec(wait_exec), .stop_exec(stop_exec), .handler_ret(handler_ret),
        .vec_ack(vec_ack), .int_take(int_take), .vec_sel(vec_sel), .stack_pc_dec(stack_pc_dec),
        .stack_index_high(stack_index_high), .set_imask(set_imask), .clr_imask(clr_imask),
        .drop_prefetch(drop_prefetch), .cpu_clk_en(cpu_clk_en),
        .base_clock_output(base_clock_output), .break_mode(break_mode),
        .break_clear_allow(break_clear_allow));
    exclp_cpu_model u_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .int_take(int_take), .slow(slow),
        .vec_ack(vec_ack));

    // =======================================
    // Clocks: 4 ns system clock, oscillator at one eighth, falls counted
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        osc_div <= osc_div + 2'h1;
        if (osc_div == 2'h3) begin
            osc_clk <= ~osc_clk;
            n_falls <= n_falls + osc_clk;
        end
    end

    // =======================================
    // Tasks
    task automatic report_and_stop;
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Instruction end or handler return, one cycle
    task automatic boundary(input logic ret);
        @(posedge sys_clk);
        instr_done <= !ret;
        handler_ret <= ret;
        @(posedge sys_clk);
        instr_done <= 1'b0;
        handler_ret <= 1'b0;
    endtask
    // Watch n edges, record takes and what came with them
    task automatic watch(input integer n);
        integer j;
        took = 0;
        drop_seen = 1'b0;
        clr_seen = 1'b0;
        for (j = 0; j < n; j = j + 1) begin
            @(posedge sys_clk);
            drop_seen = drop_seen | drop_prefetch;
            clr_seen = clr_seen | clr_imask;
            if (int_take === 1'b1) begin
                took = took + 1;
                t_vec = vec_sel;
                t_dec = stack_pc_dec;
                t_imask = set_imask;
            end
        end
    endtask

    // =======================================
    // Watchdog
    initial begin
        #360000;
        n_errors = n_errors + 1;
        report_and_stop;
    end

    // =======================================
    // Main sequence
    initial begin
        {rst_n, osc_clk, psel, penable, pwrite, break_req, i_mask, instr_done} <= 8'h00;
        {trap_exec, wait_exec, stop_exec, handler_ret, slow} <= 5'h00;
        {paddr, pwdata, irq_req, irq_en, osc_div} <= 84'h0;
        rows = '{'{1'b0, 17'h00000, 16'hFE04, 32'h00, 1'b0}, '{1'b1, 17'h00000, 16'hFE04, 32'h00, 1'b0},
            '{1'b0, 17'h00000, 16'hFE04, 32'h00, 1'b0}, '{1'b0, 17'h0003F, 16'hFE04, 32'hFC, 1'b0},
            '{1'b0, 17'h00015, 16'hFE04, 32'h54, 1'b0}, '{1'b0, 17'h0FE00, 16'hFE04, 32'h00, 1'b0},
            '{1'b0, 17'h001C0, 16'hFE08, 32'h07, 1'b0}, '{1'b0, 17'h00080, 16'hFE08, 32'h02, 1'b0},
            '{1'b0, 17'h18000, 16'hFE0C, 32'h03, 1'b0}, '{1'b0, 17'h10000, 16'hFE0C, 32'h02, 1'b0},
            '{1'b0, 17'h1FFFF, 16'hFE00, 32'h00, 1'b1}};
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        `CHK("clk_en", 1'b1, cpu_clk_en)
        `CHK("allow", 1'b1, break_clear_allow)
        // Status registers, one write that must not stick
        for (i = 0; i <= 10; i = i + 1) begin
            irq_req <= rows[i].req;
            apb(rows[i].wr, rows[i].addr, 32'hFF);
            if (!rows[i].wr) `CHK("flags", {rows[i].exp, rows[i].err}, {rd, er})
        end
        // Priority, then a latched choice that a newcomer cannot displace
        {irq_en, irq_req, slow} <= {17'h1FFFF, 17'h00014, 1'b1};
        boundary(1'b0);
        watch(4);
        `CHK("prio", {32'd1, 5'h03, 1'b1, 1'b1}, {took, t_vec, t_dec, t_imask})
        irq_req <= 17'h00015;
        boundary(1'b0);
        watch(4);
        `CHK("latched", 0, took)
        watch(8);
        boundary(1'b0);
        watch(4);
        `CHK("next", {32'd1, 5'h01}, {took, t_vec})
        watch(10);
        // Masked, then disabled: no take
        {irq_req, i_mask} <= {17'h00002, 1'b1};
        boundary(1'b0);
        watch(8);
        `CHK("masked", 0, took)
        {i_mask, irq_en} <= {1'b0, 17'h00000};
        boundary(1'b0);
        watch(8);
        `CHK("disabled", 0, took)
        // Software trap under mask
        {i_mask, trap_exec, irq_en} <= {1'b1, 1'b1, 17'h1FFFF};
        boundary(1'b0);
        trap_exec <= 1'b0;
        watch(4);
        `CHK("trap", {32'd1, 5'h00, 1'b0}, {took, t_vec, t_dec})
        watch(10);
        // Pending request at handler return
        i_mask <= 1'b0;
        boundary(1'b1);
        watch(4);
        `CHK("ret", {32'd1, 5'h02, 1'b1}, {took, t_vec, drop_seen})
        watch(10);
        // Wait, woken by flag 9
        {irq_req, wait_exec} <= {17'h00000, 1'b1};
        boundary(1'b0);
        wait_exec <= 1'b0;
        watch(3);
        `CHK("wait", 2'h2, {clr_seen, cpu_clk_en})
        irq_req <= 17'h00100;
        watch(3);
        `CHK("wake", {32'd1, 5'h09}, {took, t_vec})
        {irq_req, slow} <= {17'h00000, 1'b0};
        watch(10);
        // Break ends wait; status bit, clear enable, zero write
        wait_exec <= 1'b1;
        boundary(1'b0);
        wait_exec <= 1'b0;
        watch(3);
        break_req <= 1'b1;
        watch(4);
        break_req <= 1'b0;
        `CHK("brk", {32'd1, 5'h00}, {took, t_vec})
        watch(4);
        `CHK("brk_mode", 2'h2, {break_mode, break_clear_allow})
        apb(1'b0, `EXCLP_ADDR_BRK_STATUS, 32'h0);
        `CHK("sw_set", 1'b1, rd[1])
        apb(1'b1, `EXCLP_ADDR_BRK_FLAGCTL, 32'h80);
        watch(2);
        `CHK("allow_en", 1'b1, break_clear_allow)
        apb(1'b1, `EXCLP_ADDR_BRK_STATUS, 32'h0);
        apb(1'b0, `EXCLP_ADDR_BRK_STATUS, 32'h0);
        `CHK("sw_clr", 1'b0, rd[1])
        apb(1'b1, `EXCLP_ADDR_BRK_FLAGCTL, 32'h0);
        boundary(1'b1);
        watch(3);
        `CHK("brk_end", 1'b0, break_mode)
        // Stop recovery, short then long
        for (k = 0; k < 2; k = k + 1) begin
            apb(1'b1, `EXCLP_ADDR_CONFIG_ONE, {31'h0, k == 0});
            stop_exec <= 1'b1;
            boundary(1'b0);
            stop_exec <= 1'b0;
            watch(3);
            `CHK("stop", 2'h0, {base_clock_output, cpu_clk_en})
            f0 = n_falls;
            irq_req <= 17'h00001;
            for (i = 0; i < 40000 && cpu_clk_en !== 1'b1; i = i + 1) @(posedge sys_clk);
            f0 = n_falls - f0 - (k == 0 ? 32 : 4096);
            `CHK("recov", 1'b1, f0 >= 0 && f0 <= 2)
            watch(3);
            `CHK("stop_wake", {32'd1, 5'h01, 1'b1}, {took, t_vec, base_clock_output})
            irq_req <= 17'h00000;
            watch(10);
        end
        // Reset in mid-wait
        wait_exec <= 1'b1;
        boundary(1'b0);
        wait_exec <= 1'b0;
        watch(3);
        rst_n <= 1'b0;
        watch(2);
        rst_n <= 1'b1;
        watch(1);
        `CHK("rst_wait", 2'h3, {cpu_clk_en, base_clock_output})
        report_and_stop;
    end
endmodule
